/* branch_condition.sv */
// Condition test for transfer-control instructions
`timescale 1ns/100ps
`include "script_exec_defs.svh"
module branch_condition
  import script_exec_pkg::*;
(
  input wire logic [31:0] instr,
  input wire logic carry,
  input wire logic [2:0] phase,
  input wire logic atn_active,
  input wire logic target_mode,
  input wire logic [7:0] first_byte,
  output logic taken
);
  logic result;

  always_comb
  begin
    result = 1'b1;
    if (instr[`F_CARRY_TEST])
      result = result & carry; // [RULE10]
    if (instr[`F_CMP_PHASE])
      // A target has no incoming phase; it tests attention instead
      result = result & (target_mode ? atn_active : (phase == instr[`F_PHASE])); // [RULE18] [RULE10]
    if (instr[`F_CMP_DATA])
      result = result & (((first_byte ^ instr[`F_VALUE]) & ~instr[`F_MASK]) == 8'h00); // [RULE23]
    taken = (result == instr[`F_IF_TRUE]); // [RULE10]
  end
endmodule // branch_condition

/* exec_properties.sv */
// Handshake and halt checks on the executor ports
`timescale 1ns/100ps
module exec_properties
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic interrupt_request_n,
  input wire logic sequencer_halted
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence resp_up;
    ##2 bvalid;
  endsequence
  chk_write_answer: assert property (both_taken |-> resp_up) else $error("write response late");
  chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
  chk_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped");
  chk_read_answer: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
  chk_ready_block: assert property (bvalid |-> !awready && !wready) else $error("write taken during response");
  chk_arready_gate: assert property (arready != rvalid) else $error("arready wrong");
  chk_irq_halts: assert property (!interrupt_request_n |-> sequencer_halted) else $error("irq without halt");
  chk_irq_release: assert property ($rose(interrupt_request_n) |-> $rose(bvalid)) else $error("irq freed alone");
  chk_reset_idle: assert property ($rose(aresetn) |-> interrupt_request_n && !sequencer_halted && !bvalid && !rvalid)
    else $error("not idle after reset");
endmodule // exec_properties
bind script_executor exec_properties chk_i (.*);

/* script_alu.sv */
// Byte operator unit: load, shifts through carry, logic and adds
`timescale 1ns/100ps
`include "script_exec_defs.svh"
module script_alu
  import script_exec_pkg::*;
(
  input wire logic [2:0] op,
  input wire logic [7:0] src,
  input wire logic [7:0] operand,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic carry_out,
  output logic carry_write
);
  logic [8:0] sum;

  always_comb
  begin
    sum = {1'b0, src} + {1'b0, operand} + ((op == `OP_ADDC) ? {8'h00, carry_in} : 9'h000); // [RULE6]
    result = operand;
    carry_out = carry_in;
    carry_write = 1'b0;
    unique case (op)
      `OP_LOAD: result = operand; // [RULE3]
      `OP_SHL:
      begin
        result = {src[6:0], carry_in}; // [RULE4]
        carry_out = src[7];
        carry_write = 1'b1;
      end
      `OP_OR: result = src | operand; // [RULE5]
      `OP_XOR: result = src ^ operand; // [RULE5]
      `OP_AND: result = src & operand; // [RULE5]
      `OP_SHR:
      begin
        result = {carry_in, src[7:1]}; // [RULE4]
        carry_out = src[0];
        carry_write = 1'b1;
      end
      `OP_ADD, `OP_ADDC:
      begin
        result = sum[7:0]; // [RULE6]
        carry_out = sum[8]; // [RULE25]
        carry_write = 1'b1;
      end
    endcase
  end
endmodule // script_alu

/* script_exec_defs.svh */
// Register offsets, instruction fields and codes for the script executor
`ifndef SCRIPT_EXEC_DEFS_SVH
`define SCRIPT_EXEC_DEFS_SVH
`define ADDR_INSTR_WORD 8'h00
`define ADDR_TARGET_WORD 8'h04
`define ADDR_SCRIPT_POINTER 8'h08
`define ADDR_RETURN_HOLDER 8'h0C
`define ADDR_STATUS 8'h10
`define ADDR_FIRST_BYTE 8'h14
`define ADDR_REG_INDEX 8'h18
`define ADDR_REG_DATA 8'h1C
`define ST_CARRY 0
`define ST_HALTED 1
`define ST_FLY 2
`define ST_ILLEGAL 3
`define ST_TARGET 4
`define F_TYPE 31:30
`define F_OPC 29:27
`define F_OPER 26:24
`define F_PHASE 26:24
`define F_REL 23
`define F_USE_FB 23
`define F_REGSEL 22:16
`define F_IMM 15:8
`define F_CARRY_TEST 21
`define F_IF_TRUE 19
`define F_CMP_DATA 18
`define F_CMP_PHASE 17
`define F_MASK 15:8
`define F_VALUE 7:0
`define F_FLY 2
`define TYPE_RW 2'h1
`define TYPE_TC 2'h2
`define RW_MODIFY 3'h7
`define RW_TO_FB 3'h6
`define RW_FROM_FB 3'h5
`define TC_JUMP 3'h0
`define TC_CALL 3'h1
`define TC_RETURN 3'h2
`define TC_INTR 3'h3
`define OP_LOAD 3'h0
`define OP_SHL 3'h1
`define OP_OR 3'h2
`define OP_XOR 3'h3
`define OP_AND 3'h4
`define OP_SHR 3'h5
`define OP_ADD 3'h6
`define OP_ADDC 3'h7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* script_exec_pkg.sv */
// Types shared by the script executor
package script_exec_pkg;
  typedef enum logic [1:0] {
    RUN = 2'b01,
    HALT = 2'b10
  } exec_state_e;

  typedef struct packed {
    exec_state_e state;
    logic [31:0] instr;
    logic [31:0] script_pointer_save;
    logic [31:0] sp;
    logic [31:0] ret;
    logic [7:0] fb;
    logic carry;
    logic fly;
    logic illegal;
    logic target;
    logic irq_n;
    logic [6:0] reg_index;
    logic [127:0][7:0] regs;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic req_prev;
    logic [2:0] phase;
  } core_s;
endpackage

/* script_executor.sv */
// Script executor: register ops and transfer control behind an AXI4-Lite slave
// How it works
// [RULE1] Read-modify-write returns result to same register
// [RULE2] Opcodes 111 modify, 110 to first byte, 101 from
// [RULE3] Operator 000 loads the immediate byte
// [RULE4] Shifts pass through carry both ways
// [RULE5] Operators 010/011/100 are OR, XOR, AND
// [RULE6] Operator 110 adds plain, 111 adds with carry
// [RULE7] Move-from uses first byte as source
// [RULE8] Software subtracts by invert, add one, add
// [RULE9] Transfer opcodes: jump, call, return, interrupt, reserved
// [RULE10] Branches test carry, phase and/or masked data
// [RULE11] Taken jump loads pointer from pointer save
// [RULE12] Untaken branch leaves the pointer alone
// [RULE13] Taken call saves pointer in one holder
// [RULE14] Taken return restores pointer, never checks call
// [RULE15] Taken interrupt asserts request and halts
// [RULE16] Host writes pointer to resume after halt
// [RULE17] On-the-fly interrupt sets flag, keeps running
// [RULE18] Phase field compared with latched phase lines
// [RULE19] Software clears phase field in target mode
// [RULE20] Relative flag adds signed offset on jump/call
// [RULE21] Operand flag swaps immediate for first byte
// [RULE22] Register select and immediate fields decoded
// [RULE23] Set mask bits exclude data compare bits
// [RULE24] Reserved transfer opcode halts as illegal
// [RULE25] Adds update carry from bit 7
`timescale 1ns/100ps
`include "script_exec_defs.svh"
module script_executor
  import script_exec_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic scsi_req_n,
  input wire logic scsi_atn_n,
  input wire logic scsi_msg,
  input wire logic scsi_cd,
  input wire logic scsi_io,
  output logic interrupt_request_n,
  output logic sequencer_halted
);
  core_s c;
  core_s next_c;
  logic [7:0] alu_src;
  logic [7:0] alu_operand;
  logic [7:0] alu_result;
  logic alu_carry;
  logic alu_carry_write;
  logic branch_taken;
  logic [31:0] merged;
  logic [31:0] branch_target;
  logic [6:0] reg_sel;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] val,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[8*i +: 8] = val[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic [31:0] sign_extend24(input logic [23:0] v);
    return {{8{v[23]}}, v};
  endfunction

  assign reg_sel = c.instr[`F_REGSEL]; // [RULE22]
  assign alu_src = (c.instr[`F_OPC] == `RW_FROM_FB) ? c.fb : c.regs[reg_sel]; // [RULE7]
  assign alu_operand = c.instr[`F_USE_FB] ? c.fb : c.instr[`F_IMM]; // [RULE21] [RULE22]

  script_alu alu
  (
    .op(c.instr[`F_OPER]),
    .src(alu_src),
    .operand(alu_operand),
    .carry_in(c.carry),
    .result(alu_result),
    .carry_out(alu_carry),
    .carry_write(alu_carry_write)
  );

  branch_condition cond
  (
    .instr(c.instr),
    .carry(c.carry),
    .phase(c.phase),
    .atn_active(~c.sync2[3]),
    .target_mode(c.target),
    .first_byte(c.fb),
    .taken(branch_taken)
  );

  assign merged = merge_bytes(32'h0000_0000, c.w_data, c.w_strb);
  // Relative offset counts from the pointer, which already names the next instruction
  assign branch_target = c.instr[`F_REL] ? (c.sp + sign_extend24(merged[23:0])) : merged; // [RULE20]

  assign awready = ~c.aw_full & ~c.bvalid;
  assign wready = ~c.w_full & ~c.bvalid;
  assign arready = ~c.rvalid;
  assign bvalid = c.bvalid;
  assign bresp = c.bresp;
  assign rvalid = c.rvalid;
  assign rdata = c.rdata;
  assign rresp = c.rresp;
  assign interrupt_request_n = c.irq_n;
  assign sequencer_halted = (c.state == HALT);

  always_comb
  begin
    next_c = c;
    // Phase lines pass two flops before the latch looks at them
    next_c.sync1 = {scsi_req_n, scsi_atn_n, scsi_msg, scsi_cd, scsi_io};
    next_c.sync2 = c.sync1;
    next_c.req_prev = c.sync2[4];
    if (c.req_prev && !c.sync2[4])
      next_c.phase = c.sync2[2:0]; // [RULE18]

    if (awvalid && awready)
    begin
      next_c.aw_full = 1'b1;
      next_c.aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_c.w_full = 1'b1;
      next_c.w_data = wdata;
      next_c.w_strb = wstrb;
    end
    if (c.bvalid && bready)
      next_c.bvalid = 1'b0;

    if (c.aw_full && c.w_full && !c.bvalid)
    begin
      next_c.aw_full = 1'b0;
      next_c.w_full = 1'b0;
      next_c.bvalid = 1'b1;
      next_c.bresp = `RESP_OKAY;
      unique case ({c.aw_addr[7:2], 2'b00})
        `ADDR_INSTR_WORD:
          next_c.instr = merge_bytes(c.instr, c.w_data, c.w_strb);
        `ADDR_SCRIPT_POINTER:
        begin
          next_c.sp = merge_bytes(c.sp, c.w_data, c.w_strb);
          // Only a pointer write releases a halted sequencer
          next_c.state = RUN; // [RULE16]
          next_c.irq_n = 1'b1;
          next_c.illegal = 1'b0;
        end
        `ADDR_STATUS:
        begin
          if (c.w_strb[0])
          begin
            next_c.carry = c.w_data[`ST_CARRY];
            next_c.target = c.w_data[`ST_TARGET];
            next_c.fly = c.fly & ~c.w_data[`ST_FLY];
          end
        end
        `ADDR_REG_INDEX:
        begin
          if (c.w_strb[0])
            next_c.reg_index = c.w_data[6:0];
        end
        `ADDR_REG_DATA:
        begin
          if (c.w_strb[0])
            next_c.regs[c.reg_index] = c.w_data[7:0];
        end
        `ADDR_TARGET_WORD:
        begin
          // Executing while halted would lose the halt cause, so refuse it
          if (c.state == HALT)
            next_c.bresp = `RESP_SLVERR;
          else
          begin
            next_c.script_pointer_save = merge_bytes(c.script_pointer_save, c.w_data, c.w_strb); // [RULE15]
            if (c.instr[`F_TYPE] == `TYPE_RW)
            begin
              unique case (c.instr[`F_OPC])
                `RW_MODIFY, `RW_FROM_FB:
                begin
                  next_c.regs[reg_sel] = alu_result; // [RULE1] [RULE2] [RULE7]
                  if (alu_carry_write)
                    next_c.carry = alu_carry; // [RULE4] [RULE25]
                end
                `RW_TO_FB:
                begin
                  next_c.fb = alu_result; // [RULE2] [RULE3]
                  if (alu_carry_write)
                    next_c.carry = alu_carry; // [RULE4] [RULE25]
                end
                default:
                begin
                  next_c.state = HALT;
                  next_c.illegal = 1'b1;
                  next_c.irq_n = 1'b0;
                end
              endcase
            end
            else if (c.instr[`F_TYPE] == `TYPE_TC)
            begin
              if (c.instr[29])
              begin
                next_c.state = HALT; // [RULE24] [RULE9]
                next_c.illegal = 1'b1;
                next_c.irq_n = 1'b0;
              end
              else if (branch_taken)
              begin
                unique case (c.instr[`F_OPC])
                  `TC_JUMP:
                    next_c.sp = branch_target; // [RULE11] [RULE20]
                  `TC_CALL:
                  begin
                    next_c.ret = c.sp; // [RULE13]
                    next_c.sp = branch_target; // [RULE20]
                  end
                  `TC_RETURN:
                    next_c.sp = c.ret; // [RULE14]
                  `TC_INTR:
                  begin
                    if (c.instr[`F_FLY])
                      next_c.fly = 1'b1; // [RULE17]
                    else
                    begin
                      next_c.state = HALT; // [RULE15]
                      next_c.irq_n = 1'b0;
                    end
                  end
                  default:
                    next_c.state = c.state;
                endcase
              end
              // Untaken branch: pointer already names the next instruction [RULE12]
            end
            else
            begin
              next_c.state = HALT;
              next_c.illegal = 1'b1;
              next_c.irq_n = 1'b0;
            end
          end
        end
        default:
          next_c.bresp = `RESP_SLVERR;
      endcase
    end

    if (c.rvalid && rready)
      next_c.rvalid = 1'b0;
    if (arvalid && arready)
    begin
      next_c.rvalid = 1'b1;
      next_c.rresp = `RESP_OKAY;
      next_c.rdata = 32'h0000_0000;
      unique case ({araddr[7:2], 2'b00})
        `ADDR_INSTR_WORD:
          next_c.rdata = c.instr;
        `ADDR_TARGET_WORD:
          next_c.rdata = c.script_pointer_save;
        `ADDR_SCRIPT_POINTER:
          next_c.rdata = c.sp;
        `ADDR_RETURN_HOLDER:
          next_c.rdata = c.ret;
        `ADDR_STATUS:
        begin
          next_c.rdata[`ST_CARRY] = c.carry;
          next_c.rdata[`ST_HALTED] = (c.state == HALT);
          next_c.rdata[`ST_FLY] = c.fly;
          next_c.rdata[`ST_ILLEGAL] = c.illegal;
          next_c.rdata[`ST_TARGET] = c.target;
        end
        `ADDR_FIRST_BYTE:
          next_c.rdata[7:0] = c.fb;
        `ADDR_REG_INDEX:
          next_c.rdata[6:0] = c.reg_index;
        `ADDR_REG_DATA:
          next_c.rdata[7:0] = c.regs[c.reg_index];
        default:
          next_c.rresp = `RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      c <= '0;
      c.state <= RUN;
      c.irq_n <= 1'b1;
      c.sync1 <= 5'h1F;
      c.sync2 <= 5'h1F;
      c.req_prev <= 1'b1;
    end
    else
      c <= next_c;
  end
endmodule // script_executor

/* scsi_phase_src.sv */
// Far-side bus model: phase lines and a request pulse
`timescale 1ns/100ps
module scsi_phase_src
(
  input wire logic aclk,
  input wire logic [2:0] phase_in,
  input wire logic go,
  output logic req_n,
  output logic msg,
  output logic cd,
  output logic io
);
  logic [2:0] cnt = 3'h0;
  initial {req_n, msg, cd, io} = 4'hF;
  // Phase settles before the request and stays after it, so the latch never sees a change
  always @(posedge aclk)
  begin
    if (go)
    begin
      cnt <= 3'h6;
      {msg, cd, io} <= phase_in;
    end
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
    req_n <= !(cnt inside {[3'h1:3'h4]});
  end
endmodule // scsi_phase_src

/* tb_top.sv */
// Self-checking bench for the script executor
`timescale 1ns/100ps
`include "script_exec_defs.svh"
module tb_top;
  import script_exec_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, go = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, sp;
  logic [3:0] wstrb = 0;
  logic [2:0] ph = 0;
  logic atn_n = 1;
  logic [1:0] bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, irq_n, halted, rq_n, m, cd, io, c;
  logic [8:0] e;
  logic [7:0] f, r;
  int err_total = 0, tests_run = 0, cyc = 0;
  localparam logic [31:0] T = 32'h80000, C = 32'h200000, D = 32'h40000, P = 32'h20000;
  always #50 aclk = ~aclk;
  scsi_phase_src far (.aclk(aclk), .phase_in(ph), .go(go), .req_n(rq_n), .msg(m), .cd(cd), .io(io));
  script_executor uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .scsi_req_n(rq_n), .scsi_atn_n(atn_n), .scsi_msg(m), .scsi_cd(cd),
    .scsi_io(io), .interrupt_request_n(irq_n), .sequencer_halted(halted));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    tests_run++;
    if (s !== x)
    begin
      $display("unexpected %s expected %h seen %h", n, x, s);
      err_total++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] x);
    logic pa, pw;
    pa = 1;
    pw = 1;
    @(posedge aclk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hF, 3'h7};
    while (pa || pw)
    begin
      @(posedge aclk);
      if (pa && awready === 1'b1)
      begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready === 1'b1)
      begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
      #1;
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", x, bresp);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input string n);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    rs = rresp;
    chk(n, x, rdata);
  endtask
  task automatic ex(input logic [31:0] i, input logic [31:0] t);
    wr(`ADDR_INSTR_WORD, i, `RESP_OKAY);
    wr(`ADDR_TARGET_WORD, t, `RESP_OKAY);
  endtask
  function automatic logic [31:0] rw(input logic [2:0] o, input logic [2:0] op, input logic u, input logic [7:0] d);
    return {2'b01, o, op, u, 7'h05, d, 8'h00};
  endfunction
  function automatic logic [31:0] tc(input logic [2:0] o);
    return {2'b10, o, 27'h0};
  endfunction
  function automatic logic [8:0] alu(input logic [2:0] op, input logic [7:0] s, input logic [7:0] o, input logic c);
    case (op)
      3'h0: return {c, o};
      3'h1: return {s[7], s[6:0], c};
      3'h2: return {c, s | o};
      3'h3: return {c, s ^ o};
      3'h4: return {c, s & o};
      3'h5: return {s[0], c, s[7:1]};
      3'h6: return {1'b0, s} + {1'b0, o};
      default: return {1'b0, s} + {1'b0, o} + {8'h00, c};
    endcase
  endfunction
  task close_out;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One ceiling for the whole run; a hang anywhere ends here
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(`ADDR_STATUS, 32'h0, "status");
    wr(`ADDR_REG_INDEX, 32'h5, `RESP_OKAY);
    for (int i = 0; i < 8; i++)
    begin
      c = i[1];
      wr(`ADDR_REG_DATA, 32'h96, `RESP_OKAY);
      wr(`ADDR_STATUS, {31'h0, c}, `RESP_OKAY);
      ex(rw(`RW_MODIFY, i[2:0], 1'b0, 8'h5A), 32'h0);
      e = alu(i[2:0], 8'h96, 8'h5A, c);
      rdchk(`ADDR_REG_DATA, {24'h0, e[7:0]}, "reg");
      rdchk(`ADDR_STATUS, {31'h0, e[8]}, "carry");
    end
    f = e[7:0] + 8'h10;
    ex(rw(`RW_TO_FB, `OP_ADD, 1'b0, 8'h10), 32'h0);
    rdchk(`ADDR_FIRST_BYTE, {24'h0, f}, "fb");
    r = f ^ 8'h0F;
    ex(rw(`RW_FROM_FB, `OP_XOR, 1'b0, 8'h0F), 32'h0);
    rdchk(`ADDR_REG_DATA, {24'h0, r}, "from fb");
    ex(rw(`RW_MODIFY, `OP_OR, 1'b1, 8'h00), 32'h0);
    rdchk(`ADDR_REG_DATA, {24'h0, r | f}, "use fb");
    wr(`ADDR_STATUS, 32'h0, `RESP_OKAY);
    wr(`ADDR_SCRIPT_POINTER, 32'h100, `RESP_OKAY);
    ex(tc(`TC_JUMP) | T, 32'h200);
    rdchk(`ADDR_SCRIPT_POINTER, 32'h200, "jump");
    ex(tc(`TC_JUMP) | T | C, 32'h400);
    rdchk(`ADDR_SCRIPT_POINTER, 32'h200, "untaken");
    ex(tc(`TC_CALL) | T, 32'h300);
    rdchk(`ADDR_SCRIPT_POINTER, 32'h300, "call");
    rdchk(`ADDR_RETURN_HOLDER, 32'h200, "holder");
    ex(tc(`TC_RETURN) | T, 32'h0);
    rdchk(`ADDR_SCRIPT_POINTER, 32'h200, "return");
    ex(tc(`TC_JUMP) | T | 32'h800000, 32'h00FFFFF0);
    rdchk(`ADDR_SCRIPT_POINTER, 32'h1F0, "relative");
    ex(tc(`TC_JUMP) | T | D | 32'hF000 | f[3:0], 32'h500);
    rdchk(`ADDR_SCRIPT_POINTER, 32'h500, "masked");
    ex(tc(`TC_JUMP) | T | D | 32'hF000 | (f[3:0] ^ 4'h1), 32'h540);
    rdchk(`ADDR_SCRIPT_POINTER, 32'h500, "mismatch");
    // Subtraction through the first byte: invert, add one
    r = 8'h00 - (r | f);
    ex(rw(`RW_TO_FB, `OP_XOR, 1'b0, 8'hFF), 32'h0);
    ex(rw(`RW_FROM_FB, `OP_ADD, 1'b0, 8'h01), 32'h0);
    rdchk(`ADDR_REG_DATA, {24'h0, r}, "negate");
    for (int p = 0; p < 8; p++)
    begin
      @(posedge aclk);
      {ph, go} <= {p[2:0], 1'b1};
      @(posedge aclk);
      go <= 1'b0;
      repeat (12) @(posedge aclk);
      ex(tc(`TC_JUMP) | T | P | (p << 24), 32'h1000 + (p << 4));
      rdchk(`ADDR_SCRIPT_POINTER, 32'h1000 + (p << 4), "phase");
    end
    ex(tc(`TC_JUMP) | T | P | 32'h1000000, 32'h2000);
    rdchk(`ADDR_SCRIPT_POINTER, 32'h1070, "phase off");
    // Target mode: phase field kept clear, attention decides
    wr(`ADDR_STATUS, 32'h10, `RESP_OKAY);
    ex(tc(`TC_JUMP) | T | P, 32'h1100);
    rdchk(`ADDR_SCRIPT_POINTER, 32'h1070, "atn idle");
    atn_n <= 1'b0;
    ex(tc(`TC_JUMP) | T | P, 32'h1100);
    rdchk(`ADDR_SCRIPT_POINTER, 32'h1100, "atn");
    atn_n <= 1'b1;
    wr(`ADDR_STATUS, 32'h0, `RESP_OKAY);
    ex(tc(`TC_INTR) | T | 32'h4, 32'h700);
    rdchk(`ADDR_STATUS, 32'h4, "fly");
    ex(tc(`TC_INTR) | T, 32'h12345601);
    chk("irq", 32'h0, irq_n);
    chk("halted", 32'h1, halted);
    rdchk(`ADDR_TARGET_WORD, 32'h12345601, "vector");
    wr(`ADDR_TARGET_WORD, 32'h0, `RESP_SLVERR);
    wr(`ADDR_SCRIPT_POINTER, 32'h100, `RESP_OKAY);
    chk("irq free", 32'h1, irq_n);
    chk("running", 32'h0, halted);
    ex(tc(3'h4) | T, 32'h0);
    rdchk(`ADDR_STATUS, 32'hE, "illegal");
    chk("irq illegal", 32'h0, irq_n);
    wr(`ADDR_SCRIPT_POINTER, 32'h100, `RESP_OKAY);
    rdchk(8'h20, 32'h0, "unmapped");
    chk("rresp", `RESP_SLVERR, rs);
    wr(8'h24, 32'h0, `RESP_SLVERR);
    close_out();
  end
endmodule // tb_top
